/* File: hw/fwp_map.vh */
`ifndef FWP_MAP_VH
`define FWP_MAP_VH

// Device command codes
`define FWP_CMD_SETUP 8'h40
`define FWP_CMD_SETUP_ALT 8'h10
`define FWP_CMD_READ_ARRAY 8'hff
`define FWP_CMD_READ_STATUS 8'h70
`define FWP_CMD_CLEAR_STATUS 8'h50

// Status word bit positions
`define FWP_SR_READY 7
`define FWP_SR_ERASE_SUSP 6
`define FWP_SR_ERASE_ERR 5
`define FWP_SR_WRITE_ERR 4
`define FWP_SR_SUPPLY_ERR 3
`define FWP_SR_WRITE_SUSP 2
`define FWP_SR_PROTECT_ERR 1
`define FWP_SR_RSVD 0
`define FWP_SR_MASK 8'hfe
`define FWP_SR_ERR_MASK 8'h1a

// User operation codes
`define FWP_OP_PROGRAM 2'h0
`define FWP_OP_READ_ARRAY 2'h1
`define FWP_OP_CHECK 2'h2
`define FWP_OP_CLEAR 2'h3

// Bus timing, nanoseconds, and derived cycle counts at the system clock
`define FWP_CLK_NS 5
`define FWP_WE_PULSE_NS 50
`define FWP_WE_HIGH_NS 30
`define FWP_RD_ACCESS_NS 90
`define FWP_RD_HIGH_NS 30
`define FWP_CYC(ns) (((ns) + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
`define FWP_WE_PULSE_CYC `FWP_CYC(`FWP_WE_PULSE_NS)
`define FWP_WE_HIGH_CYC `FWP_CYC(`FWP_WE_HIGH_NS)
`define FWP_RD_ACCESS_CYC `FWP_CYC(`FWP_RD_ACCESS_NS)
`define FWP_RD_HIGH_CYC `FWP_CYC(`FWP_RD_HIGH_NS)

// Poll attempts before a program is declared hung
`define FWP_POLL_LIMIT 4000

`endif

/* File: hw/fwp_bus_cycle.v */
`timescale 1ns/1ps
`include "fwp_map.vh"

// One asynchronous bus cycle on the flash pins: strobe low, then recovery high
module fwp_bus_cycle #(
   parameter AW = 18,
   parameter DW = 16
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Cycle request
   input wire start,
   input wire is_write,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] wdata,
   output reg done_q,
   output reg [DW-1:0] rdata_q,
   // Flash pins
   output reg [AW-1:0] flash_addr_q,
   output reg flash_ce_n_q,
   output reg flash_oe_n_q,
   output reg flash_we_n_q,
   output reg [DW-1:0] flash_dq_out_q,
   output reg flash_dq_oe_q,
   input wire [DW-1:0] flash_dq_in
);
   localparam B_IDLE = 2'h0;
   localparam B_ACT = 2'h1;
   localparam B_REC = 2'h2;
   localparam [7:0] WE_PULSE = `FWP_WE_PULSE_CYC;
   localparam [7:0] WE_HIGH = `FWP_WE_HIGH_CYC;
   localparam [7:0] RD_ACCESS = `FWP_RD_ACCESS_CYC;
   localparam [7:0] RD_HIGH = `FWP_RD_HIGH_CYC;

   reg [1:0] state_q;
   reg [7:0] cnt_q;
   reg wr_q;

   // Strobes, address and data all change on the same clock edge when a cycle starts
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= B_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= {DW{1'b0}};
         flash_addr_q <= {AW{1'b0}};
         flash_ce_n_q <= 1'b1;
         flash_oe_n_q <= 1'b1;
         flash_we_n_q <= 1'b1;
         flash_dq_out_q <= {DW{1'b0}};
         flash_dq_oe_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            B_IDLE: begin
               if (start) begin
                  flash_addr_q <= addr;
                  flash_dq_out_q <= wdata;
                  flash_dq_oe_q <= is_write;
                  flash_ce_n_q <= 1'b0;
                  flash_we_n_q <= ~is_write;
                  flash_oe_n_q <= is_write;
                  wr_q <= is_write;
                  cnt_q <= is_write ? WE_PULSE : RD_ACCESS;
                  state_q <= B_ACT;
               end
            end
            B_ACT: begin
               if (cnt_q <= 8'h01) begin
                  // Data latched by the device on the rising write strobe
                  flash_we_n_q <= 1'b1;
                  flash_oe_n_q <= 1'b1;
                  flash_ce_n_q <= 1'b1;
                  if (!wr_q) begin
                     rdata_q <= flash_dq_in;
                  end
                  cnt_q <= wr_q ? WE_HIGH : RD_HIGH;
                  state_q <= B_REC;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            B_REC: begin
               // Keep driving data through hold, release before the next cycle
               if (cnt_q <= 8'h01) begin
                  flash_dq_oe_q <= 1'b0;
                  done_q <= 1'b1;
                  state_q <= B_IDLE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: begin
               state_q <= B_IDLE;
            end
         endcase
      end
   end
endmodule // fwp_bus_cycle

/* File: hw/fwp_host.v */
// Functional notes
// - Host masks reserved status bit when polling
// - Program is setup command then address/data write
// - Fresh setup per word, wait ready between
// - Full error check per write or batched
// - Write read-array command before reading memory; host skips it while array_mode_q is set
// - Clear status on error before retrying
// - Chip select decoded, output enable shared
// - Reset pin follows supply-good signal
`timescale 1ns/1ps
`include "fwp_map.vh"

module fwp_host #(
   parameter AW = 18,
   parameter DW = 16,
   parameter POLL_LIMIT = `FWP_POLL_LIMIT
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // User request
   input wire req_valid,
   input wire [1:0] req_op,
   input wire [AW-1:0] req_addr,
   input wire [DW-1:0] req_data,
   input wire req_alt_setup,
   input wire req_full_check,
   output reg req_ready_q,
   // User answer
   output reg resp_valid_q,
   output reg [7:0] resp_status_q,
   output reg [DW-1:0] resp_rdata_q,
   output reg resp_error_q,
   output reg resp_timeout_q,
   // System controls
   input wire supply_ok,
   input wire boot_unlock,
   // Flash pins
   output wire [AW-1:0] flash_addr,
   output wire flash_ce_n,
   output wire flash_oe_n,
   output wire flash_we_n,
   output wire [DW-1:0] flash_dq_out,
   output wire flash_dq_oe,
   input wire [DW-1:0] flash_dq_in,
   output reg reset_powerdown_n_q,
   output reg lock_pin_q,
   input wire ready_busy_pin
);
   localparam S_IDLE = 3'h0;
   localparam S_SETUP = 3'h1;
   localparam S_DATA = 3'h2;
   localparam S_POLL = 3'h3;
   localparam S_CLEAR = 3'h4;
   localparam S_ARRAY = 3'h5;
   localparam S_READ = 3'h6;
   localparam S_STATCMD = 3'h7;

   reg [2:0] state_q;
   reg wait_q;
   reg start_q;
   reg wr_q;
   reg [AW-1:0] baddr_q;
   reg [DW-1:0] bdata_q;
   reg [1:0] op_q;
   reg [AW-1:0] addr_q;
   reg [DW-1:0] data_q;
   reg alt_q;
   reg check_q;
   reg array_mode_q;
   reg [15:0] poll_q;
   wire done;
   wire [DW-1:0] rdata;
   wire [7:0] stat;

   // Reserved bit is never trusted, whatever the device returns
   assign stat = rdata[7:0] & `FWP_SR_MASK;

   // True when a status word carries a write, supply or protect failure
   function has_error;
      input [7:0] s;
      begin
         has_error = |(s & `FWP_SR_ERR_MASK);
      end
   endfunction

   fwp_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(start_q),
      .is_write(wr_q),
      .addr(baddr_q),
      .wdata(bdata_q),
      .done_q(done),
      .rdata_q(rdata),
      .flash_addr_q(flash_addr),
      .flash_ce_n_q(flash_ce_n),
      .flash_oe_n_q(flash_oe_n),
      .flash_we_n_q(flash_we_n),
      .flash_dq_out_q(flash_dq_out),
      .flash_dq_oe_q(flash_dq_oe),
      .flash_dq_in(flash_dq_in)
   );

   // Protection pins: reset follows supply-good so writes stop during power moves
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reset_powerdown_n_q <= 1'b0;
         lock_pin_q <= 1'b0;
      end else begin
         reset_powerdown_n_q <= supply_ok;
         lock_pin_q <= boot_unlock;
      end
   end

   // Sequencer: each bus state fires one cycle, then moves on when it is done; S_POLL refires until ready or the poll limit
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
         wait_q <= 1'b0;
         start_q <= 1'b0;
         wr_q <= 1'b0;
         baddr_q <= {AW{1'b0}};
         bdata_q <= {DW{1'b0}};
         op_q <= `FWP_OP_PROGRAM;
         addr_q <= {AW{1'b0}};
         data_q <= {DW{1'b0}};
         alt_q <= 1'b0;
         check_q <= 1'b0;
         array_mode_q <= 1'b0;
         poll_q <= 16'h0000;
         req_ready_q <= 1'b0;
         resp_valid_q <= 1'b0;
         resp_status_q <= 8'h00;
         resp_rdata_q <= {DW{1'b0}};
         resp_error_q <= 1'b0;
         resp_timeout_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         resp_valid_q <= 1'b0;
         // Device powered down forgets its mode and reads array after wake-up
         if (!reset_powerdown_n_q) begin
            array_mode_q <= 1'b1;
         end
         if (state_q != S_IDLE && !wait_q) begin
            start_q <= 1'b1;
            wait_q <= 1'b1;
            baddr_q <= addr_q;
            case (state_q)
               S_SETUP: begin
                  wr_q <= 1'b1;
                  bdata_q <= {{(DW-8){1'b0}},
                     (alt_q ? `FWP_CMD_SETUP_ALT : `FWP_CMD_SETUP)};
               end
               S_DATA: begin
                  wr_q <= 1'b1;
                  bdata_q <= data_q;
               end
               S_CLEAR: begin
                  wr_q <= 1'b1;
                  bdata_q <= {{(DW-8){1'b0}}, `FWP_CMD_CLEAR_STATUS};
               end
               S_ARRAY: begin
                  wr_q <= 1'b1;
                  bdata_q <= {{(DW-8){1'b0}}, `FWP_CMD_READ_ARRAY};
               end
               S_STATCMD: begin
                  wr_q <= 1'b1;
                  bdata_q <= {{(DW-8){1'b0}}, `FWP_CMD_READ_STATUS};
               end
               default: begin
                  wr_q <= 1'b0;
                  bdata_q <= {DW{1'b0}};
               end
            endcase
         end
         case (state_q)
            S_IDLE: begin
               req_ready_q <= 1'b1;
               if (req_valid && req_ready_q) begin
                  req_ready_q <= 1'b0;
                  op_q <= req_op;
                  addr_q <= req_addr;
                  data_q <= req_data;
                  alt_q <= req_alt_setup;
                  check_q <= req_full_check;
                  poll_q <= 16'h0000;
                  resp_timeout_q <= 1'b0;
                  case (req_op)
                     `FWP_OP_PROGRAM: begin
                        // No point programming a device held in power-down
                        if (!supply_ok) begin
                           state_q <= S_IDLE;
                           resp_valid_q <= 1'b1;
                           resp_error_q <= 1'b1;
                           resp_status_q <= 8'h00;
                           req_ready_q <= 1'b1;
                        end else begin
                           state_q <= S_SETUP;
                        end
                     end
                     `FWP_OP_READ_ARRAY: state_q <= array_mode_q ? S_READ : S_ARRAY;
                     `FWP_OP_CHECK: state_q <= S_STATCMD;
                     default: state_q <= S_CLEAR;
                  endcase
               end
            end
            S_SETUP: begin
               if (done) begin
                  wait_q <= 1'b0;
                  array_mode_q <= 1'b0;
                  state_q <= S_DATA;
               end
            end
            S_DATA, S_STATCMD: begin
               if (done) begin
                  wait_q <= 1'b0;
                  array_mode_q <= 1'b0;
                  state_q <= S_POLL;
               end
            end
            S_POLL: begin
               if (done) begin
                  wait_q <= 1'b0;
                  if (stat[`FWP_SR_READY]) begin
                     resp_status_q <= stat;
                     resp_rdata_q <= rdata;
                     // Failed check: wipe sticky bits before any retry
                     if (check_q && has_error(stat)) begin
                        resp_error_q <= 1'b1;
                        state_q <= S_CLEAR;
                     end else begin
                        resp_error_q <= 1'b0;
                        resp_valid_q <= 1'b1;
                        req_ready_q <= 1'b1;
                        state_q <= S_IDLE;
                     end
                  end else if (poll_q >= POLL_LIMIT[15:0]) begin
                     // A hung engine is reported rather than waited on forever
                     resp_status_q <= stat;
                     resp_error_q <= 1'b1;
                     resp_timeout_q <= 1'b1;
                     resp_valid_q <= 1'b1;
                     req_ready_q <= 1'b1;
                     state_q <= S_IDLE;
                  end else begin
                     poll_q <= poll_q + 16'h0001;
                  end
               end
            end
            S_CLEAR: begin
               if (done) begin
                  wait_q <= 1'b0;
                  if (op_q == `FWP_OP_CLEAR) begin
                     resp_error_q <= 1'b0;
                     resp_status_q <= 8'h00;
                  end
                  resp_valid_q <= 1'b1;
                  req_ready_q <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            S_ARRAY: begin
               if (done) begin
                  wait_q <= 1'b0;
                  array_mode_q <= 1'b1;
                  state_q <= S_READ;
               end
            end
            S_READ: begin
               if (done) begin
                  wait_q <= 1'b0;
                  resp_rdata_q <= rdata;
                  resp_error_q <= 1'b0;
                  resp_valid_q <= 1'b1;
                  req_ready_q <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // fwp_host

/* File: verif/fwp_host_sva.sv */
`timescale 1ns/1ps
// Port-level checks on the flash host controller
module fwp_host_sva #(
   parameter DW = 16
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // User side
   input wire req_valid,
   input wire req_ready_q,
   input wire resp_valid_q,
   input wire [7:0] resp_status_q,
   // System controls
   input wire supply_ok,
   input wire boot_unlock,
   // Flash pins
   input wire flash_ce_n,
   input wire flash_oe_n,
   input wire flash_we_n,
   input wire [DW-1:0] flash_dq_out,
   input wire flash_dq_oe,
   input wire reset_powerdown_n_q,
   input wire lock_pin_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Control pins copy their system inputs one cycle late
   AST_RESET_PIN:
      assert property (!$past(rst) |-> reset_powerdown_n_q == $past(supply_ok))
      else $error("reset pin does not follow supply good");
   AST_LOCK_PIN:
      assert property (!$past(rst) |-> lock_pin_q == $past(boot_unlock))
      else $error("lock pin does not follow unlock request");
   // Write strobe only with chip select and driven data
   AST_WE_GATED:
      assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
      else $error("write strobe without select or data");
   AST_WE_WIDTH:
      assert property ($fell(flash_we_n) |-> ##9 !flash_we_n ##1 flash_we_n)
      else $error("write strobe not ten cycles");
   // Data must not move while the device latches it
   AST_DQ_HOLD:
      assert property ($rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_out))
      else $error("data moved at write strobe rise");
   AST_OE_WIDTH:
      assert property ($fell(flash_oe_n) |-> ##17 !flash_oe_n ##1 flash_oe_n)
      else $error("read strobe not eighteen cycles");
   AST_NO_FIGHT:
      assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
      else $error("host drives data during a read");
   AST_RSVD_MASK:
      assert property (resp_valid_q |-> resp_status_q[0] == 1'b0)
      else $error("reserved status bit not masked");
   AST_ONE_AT_A_TIME:
      assert property (req_valid && req_ready_q |=> req_ready_q == resp_valid_q)
      else $error("ready stays high after a request");
   AST_READY_WITH_ANSWER:
      assert property (resp_valid_q |-> req_ready_q)
      else $error("answer without ready");
endmodule // fwp_host_sva

bind fwp_host fwp_host_sva #(.DW(DW)) u_sva (
   .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready_q(req_ready_q),
   .resp_valid_q(resp_valid_q), .resp_status_q(resp_status_q), .supply_ok(supply_ok),
   .boot_unlock(boot_unlock), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
   .reset_powerdown_n_q(reset_powerdown_n_q), .lock_pin_q(lock_pin_q)
);

/* File: verif/fwp_flash_model.sv */
`timescale 1ns/1ps
// Behavioural flash device: command decoder, status word and lock decision
module fwp_flash_model #(
   parameter BOOT_BASE = 18'h3c000, // Arbitrary boot split
   parameter BUSY_NS = 200
) (
   // Flash pins
   input wire [17:0] flash_addr,
   input wire flash_ce_n,
   input wire flash_oe_n,
   input wire flash_we_n,
   input wire [15:0] flash_dq_out,
   output wire [15:0] flash_dq_in,
   input wire reset_powerdown_n,
   input wire lock_pin,
   input wire program_supply,
   output wire ready_busy_pin
);
   reg [7:0] sr_q = 8'h80;
   reg [15:0] mem_q [0:15];
   reg arr_q = 1'b1;
   reg setup_q = 1'b0;
   reg erase_q = 1'b0;
   reg [15:0] last_q = 16'h0000;
   wire [15:0] val = arr_q ? mem_q[flash_addr[3:0]] : {8'h00, sr_q};
   // Write is active only while select and write strobe are both low
   wire wr_act = !flash_ce_n && !flash_we_n;
   // Released bus shows the inverse, so a stale sample cannot pass
   assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? val : ~last_q;
   assign ready_busy_pin = sr_q[7];
   always @(posedge flash_oe_n) last_q = val;
   // Reset low clears every error flag and returns to array reads
   always @(negedge reset_powerdown_n) begin
      sr_q = 8'h80;
      arr_q = 1'b1;
      setup_q = 1'b0;
   end
   // Commands latch when select or write strobe rises, whichever is first,
   // so strobes released in one step still deliver the command; reset low refuses
   always @(negedge wr_act) if (reset_powerdown_n) begin
      arr_q = 1'b0;
      if (setup_q) begin
         setup_q = 1'b0;
         if (!program_supply) sr_q = sr_q | 8'h18;
         else if (flash_addr >= BOOT_BASE && !lock_pin) sr_q = sr_q | 8'h12;
         else begin
            mem_q[flash_addr[3:0]] = flash_dq_out;
            sr_q[7] = 1'b0;
            #(BUSY_NS);
            sr_q[7] = 1'b1;
         end
      end else if (erase_q) begin
         erase_q = 1'b0;
         if (flash_dq_out[7:0] != 8'hd0) sr_q = sr_q | 8'h30;
      end else case (flash_dq_out[7:0])
         8'h40, 8'h10: setup_q = 1'b1;
         8'h20: erase_q = 1'b1;
         8'h50: sr_q = sr_q & 8'h80;
         8'hff: arr_q = 1'b1;
         default: ;
      endcase
   end
endmodule // fwp_flash_model

/* File: verif/test_flash_write_protect_status.sv */
`timescale 1ns/1ps
`include "fwp_map.vh"
module test_flash_write_protect_status;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg req_valid = 1'b0;
   reg [1:0] req_op = 2'h0;
   reg [17:0] req_addr = 18'h00000;
   reg [15:0] req_data = 16'h0000;
   reg req_alt_setup = 1'b0;
   reg req_full_check = 1'b0;
   reg supply_ok = 1'b1;
   reg boot_unlock = 1'b0;
   reg program_supply = 1'b1;
   wire req_ready_q, resp_valid_q, resp_error_q, resp_timeout_q, flash_ce_n, flash_oe_n;
   wire flash_we_n, flash_dq_oe, reset_powerdown_n_q, lock_pin_q, ready_busy_pin;
   wire [7:0] resp_status_q;
   wire [15:0] resp_rdata_q, flash_dq_out, flash_dq_in;
   wire [17:0] flash_addr;
   integer failures = 0;
   integer checked = 0;
   integer cycles = 0;
   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;
   fwp_host #(.POLL_LIMIT(8)) u_dut (
      .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_data(req_data), .req_alt_setup(req_alt_setup),
      .req_full_check(req_full_check), .req_ready_q(req_ready_q),
      .resp_valid_q(resp_valid_q), .resp_status_q(resp_status_q),
      .resp_rdata_q(resp_rdata_q), .resp_error_q(resp_error_q),
      .resp_timeout_q(resp_timeout_q), .supply_ok(supply_ok), .boot_unlock(boot_unlock),
      .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
      .flash_dq_in(flash_dq_in), .reset_powerdown_n_q(reset_powerdown_n_q),
      .lock_pin_q(lock_pin_q), .ready_busy_pin(ready_busy_pin)
   );
   fwp_flash_model u_flash (
      .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in),
      .reset_powerdown_n(reset_powerdown_n_q), .lock_pin(lock_pin_q),
      .program_supply(program_supply), .ready_busy_pin(ready_busy_pin)
   );
   task tally_and_finish;
      begin
         if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   // One user request, held until taken, then wait for its answer
   task op(input [1:0] o, input [17:0] a, input [15:0] d, input alt, input fc);
      integer n;
      begin
         @(posedge clk_sys);
         req_op <= o;
         req_addr <= a;
         req_data <= d;
         req_alt_setup <= alt;
         req_full_check <= fc;
         req_valid <= 1'b1;
         @(negedge clk_sys);
         n = 0;
         while (req_ready_q !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n = n + 1;
         end
         @(posedge clk_sys);
         req_valid <= 1'b0;
         n = 0;
         while (resp_valid_q !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n = n + 1;
         end
         chk(n < 3000, 1'b1);
         @(posedge clk_sys);
      end
   endtask
   // Hang guard, far above the roughly one thousand cycles the sequence needs
   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         tally_and_finish;
      end
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      chk({req_ready_q, reset_powerdown_n_q, lock_pin_q, flash_we_n, flash_ce_n}, 5'h03);
      rst <= 1'b0;
      op(`FWP_OP_PROGRAM, 18'h00005, 16'ha5c3, 1'b0, 1'b1);
      chk({resp_error_q, resp_status_q}, 9'h080);
      op(`FWP_OP_READ_ARRAY, 18'h00005, 16'h0000, 1'b0, 1'b0);
      chk(resp_rdata_q, 16'ha5c3);
      op(`FWP_OP_PROGRAM, 18'h3c006, 16'h1234, 1'b0, 1'b1);
      chk({resp_error_q, resp_status_q}, 9'h192);
      op(`FWP_OP_CHECK, 18'h00000, 16'h0000, 1'b0, 1'b0);
      chk(resp_status_q, 8'h80);
      // Two locked writes batched before one status check
      op(`FWP_OP_PROGRAM, 18'h3c006, 16'h1111, 1'b1, 1'b0);
      chk(resp_error_q, 1'b0);
      op(`FWP_OP_PROGRAM, 18'h3c007, 16'h2222, 1'b0, 1'b0);
      op(`FWP_OP_CHECK, 18'h00000, 16'h0000, 1'b0, 1'b0);
      chk(resp_status_q, 8'h92);
      op(`FWP_OP_CLEAR, 18'h00000, 16'h0000, 1'b0, 1'b0);
      chk(resp_status_q, 8'h00);
      op(`FWP_OP_CHECK, 18'h00000, 16'h0000, 1'b0, 1'b0);
      chk(resp_status_q, 8'h80);
      boot_unlock <= 1'b1;
      op(`FWP_OP_PROGRAM, 18'h3c006, 16'h5a5a, 1'b1, 1'b1);
      chk({resp_error_q, resp_status_q}, 9'h080);
      op(`FWP_OP_READ_ARRAY, 18'h3c006, 16'h0000, 1'b0, 1'b0);
      chk(resp_rdata_q, 16'h5a5a);
      program_supply <= 1'b0;
      op(`FWP_OP_PROGRAM, 18'h00005, 16'h0f0f, 1'b0, 1'b1);
      chk({resp_error_q, resp_status_q}, 9'h198);
      program_supply <= 1'b1;
      boot_unlock <= 1'b0;
      // Leave an error pending, then drop supply good to reset the device
      op(`FWP_OP_PROGRAM, 18'h3c007, 16'h3333, 1'b0, 1'b0);
      supply_ok <= 1'b0;
      op(`FWP_OP_PROGRAM, 18'h00005, 16'h4444, 1'b0, 1'b1);
      chk({resp_error_q, resp_status_q, reset_powerdown_n_q}, 10'h200);
      supply_ok <= 1'b1;
      op(`FWP_OP_CHECK, 18'h00000, 16'h0000, 1'b0, 1'b0);
      chk({resp_timeout_q, resp_status_q}, 9'h080);
      tally_and_finish;
   end
endmodule // test_flash_write_protect_status
